//--- common/emb_pkg.sv
// constants, types and rule overview for the external memory bus interface
// Overview of operation
// - strobe is latch pulse or address-valid level
// - address-valid level returns high at cycle end
// - strobe only on external accesses
// - high-byte enable low for high-byte writes
// - odd write strobe low for odd-byte writes
// - shared high-byte pin active only on writes
// - config bits one and two enable width pin
// - width pin low eight bit, high sixteen
// - fetch indicator high through external fetch cycle
// - clock out at half rate, even duty
// - access select latched; low forces all external
// - access select high: 2000H-5FFFH served on chip
// - code fetches below 0400H always go external
// - data 6000H-FFFFH goes to external bus
// - access select high: data 0018H-01FFH stays in register RAM
// - address and data multiplexed on two ports
// - wait input low stretches cycle until high
// - read strobe low only on external reads
// - write strobe low on writes; low-byte mode even only
package emb_pkg;
  localparam logic [15:0] SFR_LO_END = 16'h0017;
  localparam logic [15:0] REG_RAM_LO = 16'h0018;
  localparam logic [15:0] REG_RAM_HI = 16'h01FF;
  localparam logic [15:0] FORCE_EXT_HI = 16'h03FF;
  localparam logic [15:0] HI_SFR_LO = 16'h1F00;
  localparam logic [15:0] HI_SFR_HI = 16'h1FFF;
  localparam logic [15:0] ROM_LO = 16'h2000;
  localparam logic [15:0] ROM_HI = 16'h5FFF;
  localparam logic [15:0] EXT_HI_LO = 16'h6000;
  localparam logic [7:0] RESERVED_FILL = 8'hFF;
  // configuration bit positions
  localparam int CFG_STROBE_BIT = 0;
  localparam int CFG_WIDTH_BIT1 = 1;
  localparam int CFG_WIDTH_BIT2 = 2;
  localparam int CFG_HIPIN_BIT = 3;
  localparam int CFG_WRLOW_BIT = 4;
  // sixteen-bit fixed width when dynamic control off
  localparam int CFG_BUS16_BIT = 5;
  localparam int CLK_DIV = 2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT, ST_END
  } emb_state_t;
endpackage : emb_pkg

//--- rtl/emb_bus.sv
// external memory bus sequencer with multiplexed address/data ports
`timescale 1ns/1ps
module emb_bus (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] chip_config_byte,
  input wire logic external_access_select,
  input wire logic req_valid,
  input wire logic [15:0] req_addr,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic [1:0] req_be,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic req_internal,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  input wire logic wait_n,
  input wire logic bus_width,
  input wire logic [7:0] ad_lo_in,
  input wire logic [7:0] ad_hi_in,
  output logic [7:0] ad_lo_out,
  output logic [7:0] ad_hi_out,
  output logic ad_lo_oe,
  output logic ad_hi_oe,
  output logic addr_strobe,
  output logic read_n,
  output logic write_n,
  output logic high_byte_enable,
  output logic fetch_indicator,
  output logic half_rate_clock_out
);
  import emb_pkg::*;

  // three-stage synchronisers for wait, width and strap pins; two stages on the AD inputs
  logic [2:0] wait_sq, bw_sq, ea_sq;
  logic [7:0] adl1_q, adl2_q, adh1_q, adh2_q;
  logic wait_ok, bw_hi;
  // clock divider and strap state
  logic clk_q, clk_d, rise_d, rise_q, ea_lat_q, ea_lat_d, strap_done_q, strap_done_d;
  // bus sequencer state
  emb_state_t st_q, st_d;
  logic [15:0] addr_q, addr_d, wdat_q, wdat_d;
  logic wr_q, wr_d, fet_q, fet_d, w16_q, w16_d;
  logic [1:0] be_q, be_d;
  logic go_ext;
  logic ready_q, ready_d, int_q, int_d, rv_q, rv_d;
  logic [15:0] rdat_q, rdat_d;
  logic [7:0] alo_q, alo_d, ahi_q, ahi_d;
  logic aloe_q, aloe_d, ahoe_q, ahoe_d;
  logic as_q, as_d, rd_q, rd_d, wrn_q, wrn_d, hb_q, hb_d, fi_q, fi_d;

  // pins are asynchronous; only stages two and three are looked at
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_sq <= 3'h7;
      bw_sq <= 3'h7;
      adl1_q <= 8'h00;
      adl2_q <= 8'h00;
      adh1_q <= 8'h00;
      adh2_q <= 8'h00;
    end else begin
      wait_sq <= {wait_sq[1:0], wait_n};
      bw_sq <= {bw_sq[1:0], bus_width};
      adl1_q <= ad_lo_in;
      adl2_q <= adl1_q;
      adh1_q <= ad_hi_in;
      adh2_q <= adh1_q;
    end
  end
  assign wait_ok = wait_sq[1] & wait_sq[2];
  assign bw_hi = bw_sq[1] & bw_sq[2];

  // strap synchroniser runs through reset, so the pin level is already known at release
  always_ff @(posedge ref_clk) begin
    ea_sq <= {ea_sq[1:0], external_access_select};
  end

  // divider and strap capture after release of reset
  always_comb begin
    clk_d = ~clk_q;
    rise_d = ~clk_q;
    ea_lat_d = ea_lat_q;
    strap_done_d = strap_done_q;
    // latch only once stages two and three agree
    if (!strap_done_q && ea_sq[1] == ea_sq[2]) begin
      ea_lat_d = ea_sq[2];
      strap_done_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_q <= 1'b0;
      rise_q <= 1'b0;
      ea_lat_q <= 1'b1;
      strap_done_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      rise_q <= rise_d;
      ea_lat_q <= ea_lat_d;
      strap_done_q <= strap_done_d;
    end
  end

  emb_route u_route (
    .addr(req_addr),
    .is_fetch(req_fetch),
    .ext_all(~ea_lat_q),
    .go_ext(go_ext)
  );

  // sequencer: one phase per half-rate clock period, except ST_END which lasts one ref_clk cycle
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    wr_d = wr_q;
    fet_d = fet_q;
    w16_d = w16_q;
    be_d = be_q;
    ready_d = 1'b0;
    int_d = 1'b0;
    rv_d = 1'b0;
    rdat_d = rdat_q;
    alo_d = alo_q;
    ahi_d = ahi_q;
    aloe_d = aloe_q;
    ahoe_d = ahoe_q;
    as_d = as_q;
    rd_d = rd_q;
    wrn_d = wrn_q;
    hb_d = hb_q;
    fi_d = fi_q;
    unique case (st_q)
      ST_IDLE: begin
        as_d = !chip_config_byte[CFG_STROBE_BIT]; // idle: valid level high, pulse low
        if (req_valid && !ready_q && rise_q) begin
          ready_d = 1'b1;
          if (!go_ext) begin
            int_d = 1'b1; // internal: no strobe
          end else begin
            st_d = ST_ADDR;
            addr_d = req_addr;
            wdat_d = req_wdata;
            wr_d = req_write;
            fet_d = req_fetch;
            be_d = req_be;
            alo_d = req_addr[7:0];
            ahi_d = req_addr[15:8];
            aloe_d = 1'b1;
            ahoe_d = 1'b1;
            fi_d = req_fetch;
            as_d = 1'b1; // pulse rises, valid level stays high
          end
        end
      end
      ST_ADDR: begin
        if (rise_q) begin
          // strobe falls once address has stood a full phase
          as_d = 1'b0;
          w16_d = chip_config_byte[CFG_BUS16_BIT];
          if (chip_config_byte[CFG_WIDTH_BIT1] && chip_config_byte[CFG_WIDTH_BIT2]) begin
            w16_d = bw_hi;
          end
          st_d = ST_DATA;
          if (wr_q) begin
            alo_d = (be_q == 2'b10) ? wdat_q[15:8] : wdat_q[7:0];
            ahi_d = wdat_q[15:8];
            wrn_d = chip_config_byte[CFG_WRLOW_BIT] ? !(be_q[0] && !addr_q[0]) : 1'b0;
            if (chip_config_byte[CFG_HIPIN_BIT]) begin
              hb_d = !(be_q[1] || addr_q[0]);
            end else begin
              hb_d = !be_q[1];
            end
          end else begin
            aloe_d = 1'b0;
            ahoe_d = 1'b0;
            rd_d = 1'b0;
          end
        end
      end
      ST_DATA: begin
        // one extra phase: the pin synchronisers lag two edges behind the strobe
        if (rise_q) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rise_q) begin
          if (!wait_ok) begin
            st_d = ST_WAIT;
          end else begin
            st_d = ST_END;
            rv_d = !wr_q;
            rdat_d = w16_q ? {adh2_q, adl2_q} : {RESERVED_FILL & 8'h00, adl2_q};
            rd_d = 1'b1;
            wrn_d = 1'b1;
            hb_d = 1'b1;
            aloe_d = 1'b0;
            ahoe_d = 1'b0;
            as_d = !chip_config_byte[CFG_STROBE_BIT];
            fi_d = 1'b0;
          end
        end
      end
      ST_END: begin
        as_d = !chip_config_byte[CFG_STROBE_BIT];
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      addr_q <= 16'h0000;
      wdat_q <= 16'h0000;
      wr_q <= 1'b0;
      fet_q <= 1'b0;
      w16_q <= 1'b0;
      be_q <= 2'h0;
      ready_q <= 1'b0;
      int_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= 16'h0000;
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      aloe_q <= 1'b0;
      ahoe_q <= 1'b0;
      as_q <= 1'b0;
      rd_q <= 1'b1;
      wrn_q <= 1'b1;
      hb_q <= 1'b1;
      fi_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      wr_q <= wr_d;
      fet_q <= fet_d;
      w16_q <= w16_d;
      be_q <= be_d;
      ready_q <= ready_d;
      int_q <= int_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
      alo_q <= alo_d;
      ahi_q <= ahi_d;
      aloe_q <= aloe_d;
      ahoe_q <= ahoe_d;
      as_q <= as_d;
      rd_q <= rd_d;
      wrn_q <= wrn_d;
      hb_q <= hb_d;
      fi_q <= fi_d;
    end
  end

  assign req_ready = ready_q;
  assign req_internal = int_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign ad_lo_out = alo_q;
  assign ad_hi_out = ahi_q;
  assign ad_lo_oe = aloe_q;
  assign ad_hi_oe = ahoe_q;
  assign addr_strobe = as_q;
  assign read_n = rd_q;
  assign write_n = wrn_q;
  assign high_byte_enable = hb_q;
  assign fetch_indicator = fi_q;
  assign half_rate_clock_out = clk_q;
endmodule : emb_bus

//--- rtl/emb_route.sv
// address decode: internal or external route for one access
`timescale 1ns/1ps
module emb_route (
  input wire logic [15:0] addr,
  input wire logic is_fetch,
  input wire logic ext_all,
  output logic go_ext
);
  import emb_pkg::*;
  // decide the route; forced-external fetches take priority over register space
  always_comb begin
    go_ext = 1'b1;
    if (ext_all) begin
      go_ext = 1'b1;
    end else if (is_fetch && addr <= FORCE_EXT_HI) begin
      go_ext = 1'b1;
    end else if (addr <= SFR_LO_END) begin
      go_ext = 1'b0;
    end else if (addr >= REG_RAM_LO && addr <= REG_RAM_HI) begin
      go_ext = 1'b0;
    end else if (addr >= HI_SFR_LO && addr <= HI_SFR_HI) begin
      go_ext = 1'b0;
    end else if (addr >= ROM_LO && addr <= ROM_HI) begin
      go_ext = 1'b0;
    end else if (addr >= EXT_HI_LO) begin
      go_ext = 1'b1;
    end
  end
endmodule : emb_route

//--- testbench/emb_bus_checker.sv
// checker on the bus sequencer ports
`timescale 1ns/1ps
module emb_bus_checker (
  input logic ref_clk,
  input logic resetn,
  input logic [7:0] chip_config_byte,
  input logic req_valid,
  input logic req_write,
  input logic req_fetch,
  input logic req_ready,
  input logic req_internal,
  input logic rsp_valid,
  input logic ad_lo_oe,
  input logic addr_strobe,
  input logic read_n,
  input logic write_n,
  input logic high_byte_enable,
  input logic fetch_indicator,
  input logic half_rate_clock_out
);
  // one clock domain, all checks idle while reset is low
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_wr; !write_n |-> read_n; endproperty
  a_wr: assert property (p_wr) else $error("read and write together");
  property p_rd; !read_n |-> high_byte_enable; endproperty
  a_rd: assert property (p_rd) else $error("high pin on read");
  // window of three is safe: a following access cannot strobe sooner
  property p_int; req_ready && req_internal |-> (read_n && write_n)[*3]; endproperty
  a_int: assert property (p_int) else $error("strobe on internal");
  // first edge after release still sees the reset value twice
  property p_clk;
    $past(resetn) |-> half_rate_clock_out != $past(half_rate_clock_out);
  endproperty
  a_clk: assert property (p_clk) else $error("clock out stuck");
  property p_ftc; $rose(fetch_indicator) |-> $past(req_valid && req_fetch); endproperty
  a_ftc: assert property (p_ftc) else $error("fetch flag unasked");
  property p_rsp; req_ready && !req_internal && !req_write |-> ##[1:60] rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read never ends");
  property p_adv; !chip_config_byte[0] && rsp_valid |-> addr_strobe; endproperty
  a_adv: assert property (p_adv) else $error("valid level not high");
  property p_ale; chip_config_byte[0] && $rose(addr_strobe) |-> ad_lo_oe; endproperty
  a_ale: assert property (p_ale) else $error("pulse without address");
endmodule : emb_bus_checker
bind emb_bus emb_bus_checker u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .chip_config_byte(chip_config_byte),
  .req_valid(req_valid), .req_write(req_write), .req_fetch(req_fetch),
  .req_ready(req_ready), .req_internal(req_internal), .rsp_valid(rsp_valid),
  .ad_lo_oe(ad_lo_oe), .addr_strobe(addr_strobe), .read_n(read_n), .write_n(write_n),
  .high_byte_enable(high_byte_enable), .fetch_indicator(fetch_indicator),
  .half_rate_clock_out(half_rate_clock_out)
);

//--- testbench/emb_mem_model.sv
// far-side memory: answers reads, records writes, can hold wait low
`timescale 1ns/1ps
module emb_mem_model (
  input logic ref_clk,
  input logic [3:0] slow,
  input logic [7:0] ad_lo_out,
  input logic [7:0] ad_hi_out,
  input logic ad_lo_oe,
  input logic read_n,
  input logic write_n,
  output logic wait_n,
  output logic [7:0] ad_lo_in,
  output logic [7:0] ad_hi_in,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic [3:0] cnt_q = 4'h0;
  // address taken while driven and before any strobe drops
  always @(posedge ref_clk) begin
    if (ad_lo_oe && read_n && write_n) addr_q <= {ad_hi_out, ad_lo_out};
    cnt_q <= (read_n && write_n) ? 4'h0 : cnt_q + 4'h1;
    last_q <= {ad_hi_in, ad_lo_in};
    if (!write_n) {wr_addr, wr_data} <= {addr_q, ad_hi_out, ad_lo_out};
  end
  // wait held low for slow cycles; released bus toggles so stale data never matches
  assign wait_n = (read_n && write_n) || (cnt_q >= slow);
  assign {ad_hi_in, ad_lo_in} = read_n ? ~last_q : addr_q ^ 16'hA5C3;
endmodule : emb_mem_model

//--- testbench/test_external_memory_bus_interface.sv
// self-checking bench for the external bus sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_external_memory_bus_interface;
  import emb_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, external_access_select = 1'b1, bus_width = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
  logic [7:0] chip_config_byte = 8'h20;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
  logic [1:0] req_be = 2'h3;
  logic [3:0] slow = 4'h0;
  logic req_ready, req_internal, rsp_valid, wait_n, ad_lo_oe, ad_hi_oe, addr_strobe;
  logic read_n, write_n, high_byte_enable, fetch_indicator, half_rate_clock_out;
  logic [15:0] rsp_rdata, wr_addr, wr_data;
  logic [7:0] ad_lo_in, ad_hi_in, ad_lo_out, ad_hi_out;
  logic saw_hbe, saw_wr, saw_ftc;
  int errors = 0, checks_done = 0, cycles = 0;
  emb_bus DUT (
    .ref_clk(ref_clk), .resetn(resetn), .chip_config_byte(chip_config_byte),
    .external_access_select(external_access_select), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_fetch(req_fetch), .req_be(req_be),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_internal(req_internal),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wait_n(wait_n), .bus_width(bus_width),
    .ad_lo_in(ad_lo_in), .ad_hi_in(ad_hi_in), .ad_lo_out(ad_lo_out), .ad_hi_out(ad_hi_out),
    .ad_lo_oe(ad_lo_oe), .ad_hi_oe(ad_hi_oe), .addr_strobe(addr_strobe), .read_n(read_n),
    .write_n(write_n), .high_byte_enable(high_byte_enable),
    .fetch_indicator(fetch_indicator), .half_rate_clock_out(half_rate_clock_out)
  );
  emb_mem_model u_mem (
    .ref_clk(ref_clk), .slow(slow), .ad_lo_out(ad_lo_out), .ad_hi_out(ad_hi_out),
    .ad_lo_oe(ad_lo_oe), .read_n(read_n), .write_n(write_n), .wait_n(wait_n),
    .ad_lo_in(ad_lo_in), .ad_hi_in(ad_hi_in), .wr_addr(wr_addr), .wr_data(wr_data)
  );
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic give_verdict();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // bus watch; the cycle limit cuts a hang short
  always @(posedge ref_clk) begin
    if (high_byte_enable === 1'b0) saw_hbe = 1'b1;
    if (write_n === 1'b0) saw_wr = 1'b1;
    if (fetch_indicator === 1'b1) saw_ftc = 1'b1;
    cycles++;
    if (cycles > 4000) begin
      errors++;
      give_verdict();
    end
  end
  // one access held until taken, read data judged at its response
  task automatic acc(input logic [15:0] a, input logic w, input logic f,
      input logic [1:0] be, input logic ei, input logic [15:0] ed);
    int n;
    logic gi;
    n = 0;
    @(posedge ref_clk);
    #2;
    {req_addr, req_write, req_fetch, req_be, req_wdata} = {a, w, f, be, a};
    req_valid = 1'b1;
    {saw_hbe, saw_wr, saw_ftc} = 3'b000;
    do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 40);
    gi = req_internal;
    `CHK(n < 40, 1'b1)
    #2;
    req_valid = 1'b0;
    `CHK(gi, ei)
    if (!w && !ei) begin
      n = 0;
      do begin @(posedge ref_clk); n++; end while (rsp_valid !== 1'b1 && n < 60);
      `CHK(n < 60, 1'b1)
      `CHK(rsp_rdata, ed)
    end
    repeat (10) @(posedge ref_clk);
    #2;
    `CHK(saw_ftc, f & ~ei)
  endtask : acc
  // address map with the strap high, reserved places left alone
  task automatic t_map();
    logic [15:0] am [8];
    am = '{REG_RAM_LO, REG_RAM_HI, 16'h0010, FORCE_EXT_HI, ROM_LO, ROM_HI, EXT_HI_LO, 16'hFFFF};
    for (int i = 0; i < 8; i++) begin
      acc(am[i], 1'b0, i inside {2, 3}, 2'h3, i inside {0, 1, 4, 5}, am[i] ^ 16'hA5C3);
    end
  endtask : t_map
  // shared high pin and write strobe per byte lane in the three write modes
  task automatic t_wr();
    logic [7:0] modes [3];
    modes = '{8'h20, 8'h28, 8'h38};
    for (int m = 0; m < 3; m++) begin
      chip_config_byte = modes[m];
      acc(16'h6001, 1'b1, 1'b0, 2'h2, 1'b0, 16'h0000);
      `CHK(saw_hbe, 1'b1)
      `CHK(saw_wr, m < 2)
      `CHK(wr_data[15:8], 8'h60)
      acc(16'h6000, 1'b1, 1'b0, 2'h1, 1'b0, 16'h0000);
      `CHK(saw_hbe, 1'b0)
      `CHK({saw_wr, wr_addr, wr_data[7:0]}, 25'h1600000)
    end
  endtask : t_wr
  // width pin low gives a byte cycle; the bench drives it per access
  task automatic t_width();
    chip_config_byte = 8'h07;
    bus_width = 1'b0;
    acc(16'h6010, 1'b0, 1'b0, 2'h3, 1'b0, (16'h6010 ^ 16'hA5C3) & 16'h00FF);
    bus_width = 1'b1;
    slow = 4'h6;
    acc(16'h6010, 1'b0, 1'b0, 2'h3, 1'b0, 16'h6010 ^ 16'hA5C3);
    slow = 4'h0;
  endtask : t_width
  // second reset with the strap low sends the on-chip range to the bus
  task automatic t_strap();
    chip_config_byte = 8'h20;
    external_access_select = 1'b0;
    resetn = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    repeat (6) @(posedge ref_clk);
    acc(ROM_LO, 1'b0, 1'b0, 2'h3, 1'b0, ROM_LO ^ 16'hA5C3);
  endtask : t_strap
  initial begin
    repeat (3) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    repeat (6) @(posedge ref_clk);
    t_map();
    t_wr();
    t_width();
    t_strap();
    give_verdict();
  end
endmodule : test_external_memory_bus_interface
